// ### hw/bes_stats_top.sv
// Bit error statistics for a main and a side pattern channel, with view cycling.
// Assumes checker flags and the debounced clear key are pulses on clk_i.
`timescale 1ns/1ps

// Behaviour
// [R1] Every bit error in received pattern data adds to the bit error count.
// [R2] Each one-second interval with any bit error adds one errored second.
// [R3] Ratio is errored bits over all bits since the last clear.
// [R4] Each one-second interval without any bit error adds one clean second.
// [R5] Clean share is clean seconds over running seconds, as a percentage.
// [R6] A second with error ratio at least one per thousand counts as severe.
// [R7] Severe share is severe seconds over running seconds, as a percentage.
// [R8] Reset or clear selects default view: bit errors with errored seconds.
// [R9] Clear key with all error counts zero advances to the next view.
// [R10] Views: ratio, then clean share, then severe; fourth press returns default.
// [R11] With side test or alternating loop, only main line cycles views.
// [R12] Bit errors as four digits; ratio as mantissa, two decimals, exponent.
// [R13] Clear key restarts the elapsed timer and zeroes all statistics; the code loads clean share with 100.00 percent instead of zero.
// [R14] One clear press zeroes main and side statistics in one cycle.
// [R15] Seconds come from a divided clock tick; each interval judged at tick.
// [R16] Counters saturate at display maximum; reset zeroes them, default view.
module bes_stats_top
    import bes_pkg::*;
#(
    parameter int TICK_CYCLES = bes_pkg::TICK_CYCLES,
    parameter int BW          = 40,
    parameter int SW          = 24
)
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    // Operator and mode
    input  wire logic              clear_key_i,
    input  wire logic              side_active_i,
    // Main channel checker
    input  wire logic              main_bit_valid_i,
    input  wire logic              main_bit_err_i,
    // Side channel checker
    input  wire logic              side_bit_valid_i,
    input  wire logic              side_bit_err_i,
    // Main channel counts
    output logic [15:0]            main_bit_err_cnt_o,
    output logic [15:0]            main_err_sec_o,
    output logic [15:0]            main_clean_sec_o,
    output logic [15:0]            main_severe_sec_o,
    output logic [SW-1:0]          elapsed_sec_o,
    // Side channel counts
    output logic [15:0]            side_bit_err_cnt_o,
    output logic [15:0]            side_err_sec_o,
    output logic [15:0]            side_clean_sec_o,
    output logic [15:0]            side_severe_sec_o,
    // Main channel derived figures
    output logic [9:0]             ratio_mant_o,
    output logic [6:0]             ratio_exp_o,
    output logic [15:0]            clean_share_o,
    output logic [15:0]            severe_share_o,
    // Views
    output bes_pkg::bes_view_t     main_view_o,
    output bes_pkg::bes_view_t     side_view_o,
    output logic                   side_line_on_o
);
    import bes_pkg::*;

    localparam int NW = BW + 16;

    // ==========================================================
    // One-second tick
    logic [31:0] tick_cnt_q, tick_cnt_d;
    logic        tick_q, tick_d;
    logic        calc_go_q, calc_go_d;

    always_comb
    begin
        tick_cnt_d = tick_cnt_q + 32'h1;
        tick_d     = 1'b0;
        calc_go_d  = tick_q;
        if (clear_key_i)
        begin
            // Restarting the divider aligns seconds to the clear
            tick_cnt_d = 32'h0;  // R13
            calc_go_d  = 1'b0;
        end
        else if (tick_cnt_q == 32'(TICK_CYCLES - 1))
        begin
            tick_cnt_d = 32'h0;  // R15
            tick_d     = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b0;
            calc_go_q  <= 1'b0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
            calc_go_q  <= calc_go_d;
        end
    end

    // ==========================================================
    // Channel counters, both cleared by the same key press
    logic [BW-1:0] m_tot_bits, m_tot_err;
    logic [SW-1:0] m_clean_raw, m_severe_raw;

    bes_chan_stats #(.BW(BW), .SW(SW)) u_main (
        .clk_i         (clk_i),
        .sys_rst_i     (sys_rst_i),
        .clear_i       (clear_key_i),
        .tick_i        (tick_q),
        .bit_valid_i   (main_bit_valid_i),
        .bit_err_i     (main_bit_err_i),
        .bit_err_cnt_o (main_bit_err_cnt_o),
        .err_sec_o     (main_err_sec_o),
        .clean_sec_o   (main_clean_sec_o),
        .severe_sec_o  (main_severe_sec_o),
        .tot_bits_o    (m_tot_bits),
        .tot_err_o     (m_tot_err),
        .tot_sec_o     (elapsed_sec_o),
        .clean_raw_o   (m_clean_raw),
        .severe_raw_o  (m_severe_raw)
    );

    bes_chan_stats #(.BW(BW), .SW(SW)) u_side (
        .clk_i         (clk_i),
        .sys_rst_i     (sys_rst_i),
        .clear_i       (clear_key_i),
        .tick_i        (tick_q),
        .bit_valid_i   (side_bit_valid_i),
        .bit_err_i     (side_bit_err_i),
        .bit_err_cnt_o (side_bit_err_cnt_o),
        .err_sec_o     (side_err_sec_o),
        .clean_sec_o   (side_clean_sec_o),
        .severe_sec_o  (side_severe_sec_o),
        .tot_bits_o    (),
        .tot_err_o     (),
        .tot_sec_o     (),
        .clean_raw_o   (),
        .severe_raw_o  ()
    );

    // ==========================================================
    // View sequencing
    bes_view_t view_q, view_d;
    logic      side_on_q, side_on_d;
    logic      all_zero_w;

    assign all_zero_w = (main_bit_err_cnt_o == 16'h0) && (main_err_sec_o == 16'h0) &&
                        (main_severe_sec_o == 16'h0) && (side_bit_err_cnt_o == 16'h0) &&
                        (side_err_sec_o == 16'h0) && (side_severe_sec_o == 16'h0);

    always_comb
    begin
        view_d    = view_q;
        side_on_d = side_active_i;
        if (clear_key_i)
        begin
            if (!all_zero_w)
                view_d = BES_VIEW_DEFAULT;  // R8
            else
            begin
                case (view_q)  // R9 R10
                    BES_VIEW_DEFAULT: view_d = BES_VIEW_RATIO;
                    BES_VIEW_RATIO:   view_d = BES_VIEW_SHARE;
                    BES_VIEW_SHARE:   view_d = BES_VIEW_SEVERE;
                    BES_VIEW_SEVERE:  view_d = BES_VIEW_DEFAULT;
                    default:          view_d = BES_VIEW_DEFAULT;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            view_q    <= BES_VIEW_DEFAULT;  // R16
            side_on_q <= 1'b0;
        end
        else
        begin
            view_q    <= view_d;
            side_on_q <= side_on_d;
        end
    end

    assign main_view_o    = view_q;
    // The side line never cycles; it always shows its default form
    assign side_view_o    = BES_VIEW_DEFAULT;  // R11
    assign side_line_on_o = side_on_q;

    // ==========================================================
    // Serial ratio engine: one restoring divider shared by three jobs.
    // Trades latency (under 150 cycles per second) for a single subtractor.
    bes_div_t      st_q, st_d;
    logic [1:0]    job_q, job_d;
    logic [NW-1:0] num_q, num_d, den_q, den_d;
    logic [13:0]   quo_q, quo_d;
    logic [3:0]    idx_q, idx_d;
    logic [6:0]    exp_q, exp_d;
    logic [9:0]    mant_q, mant_d;
    logic [6:0]    rexp_q, rexp_d;
    logic [15:0]   csh_q, csh_d, ssh_q, ssh_d;
    logic [NW-1:0] shifted_w;

    assign shifted_w = den_q << idx_q;

    always_comb
    begin
        st_d = st_q; job_d = job_q; num_d = num_q; den_d = den_q;
        quo_d = quo_q; idx_d = idx_q; exp_d = exp_q;
        mant_d = mant_q; rexp_d = rexp_q; csh_d = csh_q; ssh_d = ssh_q;
        case (st_q)
            BES_DIV_IDLE:
                if (calc_go_q)
                begin
                    job_d = 2'd0;
                    st_d  = BES_DIV_LOAD;
                end
            BES_DIV_LOAD:
            begin
                exp_d = 7'h0;
                quo_d = 14'h0;
                idx_d = 4'(QUO_BITS - 1);
                st_d  = BES_DIV_DIVIDE;
                if (job_q == 2'd0)
                begin
                    num_d = NW'(m_tot_err) * NW'(RATIO_SCALE);  // R3
                    den_d = NW'(m_tot_bits);
                    st_d  = BES_DIV_SCALE;
                    if (m_tot_err == '0)
                    begin
                        mant_d = 10'h0;
                        rexp_d = 7'h0;
                        st_d   = BES_DIV_STORE;
                    end
                end
                else
                begin
                    num_d = NW'((job_q == 2'd1) ? m_clean_raw : m_severe_raw) * NW'(SHARE_SCALE);
                    den_d = NW'(elapsed_sec_o);  // R5 R7
                    if (elapsed_sec_o == '0)
                        st_d = BES_DIV_STORE;
                end
            end
            BES_DIV_SCALE:
                // Normalise so the quotient lands in 1.00 .. 9.99
                if (num_q < NW'(den_q * NW'(RATIO_SCALE)) && exp_q < EXP_MAX)
                begin
                    num_d = NW'(num_q * NW'(10));  // R12
                    exp_d = exp_q + 7'h1;
                end
                else
                    st_d = BES_DIV_DIVIDE;
            BES_DIV_DIVIDE:
            begin
                if (num_q >= shifted_w)
                begin
                    num_d        = num_q - shifted_w;
                    quo_d[idx_q] = 1'b1;
                end
                idx_d = idx_q - 4'h1;
                if (idx_q == 4'h0)
                begin
                    st_d = BES_DIV_STORE;
                    if (job_q == 2'd0)
                    begin
                        mant_d = quo_d[9:0];  // R12
                        rexp_d = exp_q;
                    end
                    else if (job_q == 2'd1)
                        csh_d = {2'b00, quo_d};  // R5
                    else
                        ssh_d = {2'b00, quo_d};  // R7
                end
            end
            BES_DIV_STORE:
            begin
                job_d = job_q + 2'd1;
                st_d  = (job_q == 2'd2) ? BES_DIV_IDLE : BES_DIV_LOAD;
            end
            default:
                st_d = BES_DIV_IDLE;
        endcase
        if (clear_key_i)
        begin
            st_d   = BES_DIV_IDLE;
            mant_d = 10'h0;
            rexp_d = 7'h0;
            csh_d  = SHARE_FULL;
            ssh_d  = 16'h0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            st_q <= BES_DIV_IDLE; job_q <= 2'd0; num_q <= '0; den_q <= '0;
            quo_q <= '0; idx_q <= '0; exp_q <= '0;
            mant_q <= '0; rexp_q <= '0; csh_q <= SHARE_FULL; ssh_q <= '0;
        end
        else
        begin
            st_q <= st_d; job_q <= job_d; num_q <= num_d; den_q <= den_d;
            quo_q <= quo_d; idx_q <= idx_d; exp_q <= exp_d;
            mant_q <= mant_d; rexp_q <= rexp_d; csh_q <= csh_d; ssh_q <= ssh_d;
        end
    end

    assign ratio_mant_o   = mant_q;
    assign ratio_exp_o    = rexp_q;
    assign clean_share_o  = csh_q;
    assign severe_share_o = ssh_q;

    // ==========================================================
    // Checks
    view_default_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R8
        clear_key_i && !all_zero_w |=> view_q == BES_VIEW_DEFAULT)
        else $error("clear with errors did not select default view");
    view_step_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R9
        clear_key_i && all_zero_w && view_q != BES_VIEW_SEVERE |=> view_q == $past(view_q) + 2'd1)
        else $error("clear at zero did not advance view");
    view_wrap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R10
        clear_key_i && all_zero_w && view_q == BES_VIEW_SEVERE |=> view_q == BES_VIEW_DEFAULT)
        else $error("fourth press did not return to default");
    side_view_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R11
        side_on_q |-> side_view_o == BES_VIEW_DEFAULT)
        else $error("side line left default form");
    both_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R14
        clear_key_i |=> main_bit_err_cnt_o == 16'h0 && side_bit_err_cnt_o == 16'h0 &&
                        main_err_sec_o == 16'h0 && side_err_sec_o == 16'h0)
        else $error("channels not cleared together");
    tick_period_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R15
        tick_q |-> $past(tick_cnt_q) == 32'(TICK_CYCLES - 1) && tick_cnt_q == 32'h0)
        else $error("second tick off period");
    ratio_form_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R3 R12
        !clear_key_i && st_q == BES_DIV_DIVIDE && idx_q == 4'h0 && job_q == 2'd0 && exp_q < EXP_MAX
        |=> mant_q >= MANT_MIN && mant_q <= MANT_MAX)
        else $error("ratio mantissa out of range");
    share_range_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R5 R7
        st_q == BES_DIV_STORE |-> csh_q <= SHARE_FULL && ssh_q <= SHARE_FULL)
        else $error("share above one hundred percent");

endmodule

// ### hw/bes_pkg.sv
// Shared constants and types for the bit error statistics block.
// Assumes one 100 MHz system clock and per-bit error flags from a checker.
package bes_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 32'h0000000A;
    localparam int SECOND_NS     = 32'h3B9ACA00;
    localparam int TICK_CYCLES   = SECOND_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Display limits and scaling
    localparam logic [15:0] BE_MAX      = 16'h270F;  // 9999, four digits
    localparam logic [15:0] SEC_MAX     = 16'h03E7;  // 999, three digits
    localparam logic [15:0] SHARE_FULL  = 16'h2710;  // 100.00 percent
    localparam int          SEVERE_DIV  = 32'h000003E8;  // one error per thousand bits
    localparam int          RATIO_SCALE = 32'h00000064;  // two fractional digits
    localparam int          SHARE_SCALE = 32'h00002710;  // hundredths of a percent
    localparam logic [9:0]  MANT_MIN    = 10'h064;
    localparam logic [9:0]  MANT_MAX    = 10'h3E7;
    localparam logic [6:0]  EXP_MAX     = 7'h63;
    localparam int          QUO_BITS    = 32'h0000000E;

    // ==========================================================
    // Views and divider sequencing
    typedef enum logic [1:0] {
        BES_VIEW_DEFAULT = 2'b00,
        BES_VIEW_RATIO   = 2'b01,
        BES_VIEW_SHARE   = 2'b10,
        BES_VIEW_SEVERE  = 2'b11
    } bes_view_t;

    typedef enum logic [2:0] {
        BES_DIV_IDLE   = 3'b000,
        BES_DIV_LOAD   = 3'b001,
        BES_DIV_SCALE  = 3'b010,
        BES_DIV_DIVIDE = 3'b011,
        BES_DIV_STORE  = 3'b100
    } bes_div_t;

    function automatic logic [15:0] bes_sat_inc(input logic [15:0] v, input logic [15:0] max);
        bes_sat_inc = (v >= max) ? max : v + 16'h0001;
    endfunction

endpackage

// ### hw/bes_chan_stats.sv
// Per-channel counters: bit errors, errored, clean and severe seconds.
// Assumes tick_i and clear_i are one-cycle pulses on clk_i.
`timescale 1ns/1ps

module bes_chan_stats
#(
    parameter int BW = 40,
    parameter int SW = 24
)
(
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    // Control
    input  wire logic          clear_i,
    input  wire logic          tick_i,
    // Checker flags
    input  wire logic          bit_valid_i,
    input  wire logic          bit_err_i,
    // Displayed counts
    output logic [15:0]        bit_err_cnt_o,
    output logic [15:0]        err_sec_o,
    output logic [15:0]        clean_sec_o,
    output logic [15:0]        severe_sec_o,
    // Raw totals for the ratio engine
    output logic [BW-1:0]      tot_bits_o,
    output logic [BW-1:0]      tot_err_o,
    output logic [SW-1:0]      tot_sec_o,
    output logic [SW-1:0]      clean_raw_o,
    output logic [SW-1:0]      severe_raw_o
);
    import bes_pkg::*;

    logic [15:0]   be_q, be_d, es_q, es_d, efs_q, efs_d, ses_q, ses_d;
    logic [BW-1:0] tb_q, tb_d, te_q, te_d;
    logic [SW-1:0] ts_q, ts_d, cr_q, cr_d, sr_q, sr_d;
    logic [31:0]   ib_q, ib_d, ie_q, ie_d;
    logic          severe_w;

    // ==========================================================
    // Interval classification and accumulation
    assign severe_w = (ie_q != 32'h0) &&
                      (({10'h0, ie_q} * 42'(SEVERE_DIV)) >= {10'h0, ib_q});  // R6

    always_comb
    begin
        be_d = be_q; es_d = es_q; efs_d = efs_q; ses_d = ses_q;
        tb_d = tb_q; te_d = te_q; ts_d = ts_q; cr_d = cr_q; sr_d = sr_q;
        ib_d = ib_q; ie_d = ie_q;
        if (clear_i)
        begin
            // Clear also restarts the elapsed time
            be_d = '0; es_d = '0; efs_d = '0; ses_d = '0;  // R13
            tb_d = '0; te_d = '0; ts_d = '0; cr_d = '0; sr_d = '0;
            ib_d = '0; ie_d = '0;
        end
        else
        begin
            if (bit_valid_i)
            begin
                ib_d = ib_q + 32'h1;
                if (tb_q != '1)
                    tb_d = tb_q + BW'(1);  // R3
                if (bit_err_i)
                begin
                    be_d = bes_sat_inc(be_q, BE_MAX);  // R1 R16
                    ie_d = ie_q + 32'h1;
                    if (te_q != '1)
                        te_d = te_q + BW'(1);
                end
            end
            if (tick_i)
            begin
                // A bit arriving with the tick belongs to the new interval
                ib_d = {31'h0, bit_valid_i};  // R15
                ie_d = {31'h0, bit_valid_i & bit_err_i};
                if (ts_q != '1)
                    ts_d = ts_q + SW'(1);
                if (ie_q != 32'h0)
                    es_d = bes_sat_inc(es_q, SEC_MAX);  // R2
                else
                begin
                    efs_d = bes_sat_inc(efs_q, SEC_MAX);  // R4
                    if (cr_q != '1)
                        cr_d = cr_q + SW'(1);
                end
                if (severe_w)
                begin
                    ses_d = bes_sat_inc(ses_q, SEC_MAX);  // R6
                    if (sr_q != '1)
                        sr_d = sr_q + SW'(1);
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            be_q <= '0; es_q <= '0; efs_q <= '0; ses_q <= '0;  // R16
            tb_q <= '0; te_q <= '0; ts_q <= '0; cr_q <= '0; sr_q <= '0;
            ib_q <= '0; ie_q <= '0;
        end
        else
        begin
            be_q <= be_d; es_q <= es_d; efs_q <= efs_d; ses_q <= ses_d;
            tb_q <= tb_d; te_q <= te_d; ts_q <= ts_d; cr_q <= cr_d; sr_q <= sr_d;
            ib_q <= ib_d; ie_q <= ie_d;
        end
    end

    assign bit_err_cnt_o = be_q;
    assign err_sec_o     = es_q;
    assign clean_sec_o   = efs_q;
    assign severe_sec_o  = ses_q;
    assign tot_bits_o    = tb_q;
    assign tot_err_o     = te_q;
    assign tot_sec_o     = ts_q;
    assign clean_raw_o   = cr_q;
    assign severe_raw_o  = sr_q;

    // ==========================================================
    // Checks
    be_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R1
        !clear_i && bit_valid_i && bit_err_i && be_q < BE_MAX |=> be_q == $past(be_q) + 16'h0001)
        else $error("bit error not counted");
    es_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R2
        tick_i && !clear_i && ie_q != 32'h0 && es_q < SEC_MAX |=> es_q == $past(es_q) + 16'h0001)
        else $error("errored second not counted");
    efs_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R4
        tick_i && !clear_i && ie_q == 32'h0 |=> es_q == $past(es_q) && efs_q != 16'h0000)
        else $error("clean second misclassified");
    ses_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R6
        tick_i && !clear_i && ie_q != 32'h0 && ({10'h0, ie_q} * 42'(SEVERE_DIV)) < {10'h0, ib_q}
        |=> ses_q == $past(ses_q))
        else $error("light second counted as severe");
    sat_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R16
        be_q == BE_MAX && !clear_i |=> be_q == BE_MAX)
        else $error("bit error count wrapped");
    clear_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // R13
        clear_i |=> be_q == 16'h0000 && es_q == 16'h0000 && ts_q == '0 && ses_q == 16'h0000)
        else $error("clear left statistics standing");

endmodule

// ### dv/bes_bit_src.sv
// Behavioural pattern checker feeding per-bit error flags to one channel.
// Assumes the bench changes en_i and err_i on the falling edge of clk_i.
`timescale 1ns/1ps

module bes_bit_src
(
    // Clock
    input  wire logic clk_i,
    // Bench control
    input  wire logic en_i,
    input  wire logic err_i,
    // Flags toward the statistics block
    output logic      bit_valid_o,
    output logic      bit_err_o
);
    // ==========================================================
    // Flag outputs
    logic junk_q = 1'b0;

    // The error line carries no meaning without valid, so it toggles there
    always @(negedge clk_i)
    begin
        junk_q <= ~junk_q;
    end

    assign bit_valid_o = en_i;
    assign bit_err_o   = en_i ? err_i : junk_q;
endmodule

// ### dv/bes_stats_top_tb.sv
// Self-checking bench for the main and side channel error statistics.
// Assumes the design package and a short second tick of TK cycles.
`timescale 1ns/1ps

module bes_stats_top_tb;
    import bes_pkg::*;
    // ==========================================================
    // Signals
    // Long enough that one interval can hold over a thousand bits with one error
    localparam int TK = 1200;
    logic        clk_i = 0, sys_rst_i = 1, clear_key_i = 0, side_active_i = 0;
    logic        m_en = 0, m_err = 0, s_en = 0, s_err = 0;
    wire logic   mv, me, sv, se;
    logic [15:0] mbe, mes, mcs, mss, sbe, severe_second_count, scs, sss, csh, ssh;
    logic [23:0] el;
    logic [9:0]  mant;
    logic [6:0]  ex;
    bes_view_t   mvw, svw;
    logic        slo;
    int          n_mismatch = 0, samples_checked = 0, ne, i;
    logic [31:0] seed = 32'hB460F58E;

    bes_bit_src u_msrc (.clk_i(clk_i), .en_i(m_en), .err_i(m_err), .bit_valid_o(mv), .bit_err_o(me));
    bes_bit_src u_ssrc (.clk_i(clk_i), .en_i(s_en), .err_i(s_err), .bit_valid_o(sv), .bit_err_o(se));
    bes_stats_top #(.TICK_CYCLES(TK), .BW(40), .SW(24)) u_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .clear_key_i(clear_key_i),
        .side_active_i(side_active_i), .main_bit_valid_i(mv), .main_bit_err_i(me),
        .side_bit_valid_i(sv), .side_bit_err_i(se), .main_bit_err_cnt_o(mbe),
        .main_err_sec_o(mes), .main_clean_sec_o(mcs), .main_severe_sec_o(mss),
        .elapsed_sec_o(el), .side_bit_err_cnt_o(sbe), .side_err_sec_o(severe_second_count),
        .side_clean_sec_o(scs), .side_severe_sec_o(sss), .ratio_mant_o(mant),
        .ratio_exp_o(ex), .clean_share_o(csh), .severe_share_o(ssh),
        .main_view_o(mvw), .side_view_o(svw), .side_line_on_o(slo));

    // ==========================================================
    // Helpers
    initial forever #5 clk_i = ~clk_i;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic press();
        @(negedge clk_i) clear_key_i = 1;
        @(negedge clk_i) clear_key_i = 0;
    endtask

    // Bounded wait: a tick that never comes shows up as an elapsed mismatch
    task automatic wait_sec(input logic [23:0] n);
        int k;
        k = 0;
        while (el !== n && k < TK + 10)
        begin
            @(negedge clk_i);
            k++;
        end
        chk("elapsed_sec", n, el);
        repeat (2) @(negedge clk_i);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial
    begin
        repeat (10) @(negedge clk_i);
        sys_rst_i = 0;
        chk("reset bit errors", 0, mbe);
        chk("reset view", BES_VIEW_DEFAULT, mvw);
        chk("reset clean share", SHARE_FULL, csh);
        press();
        chk("view first press", BES_VIEW_RATIO, mvw);
        $display("test reset_view done");
        seed = lfsr(seed);
        ne = int'(seed[2:0]) + 1;
        m_en = 1;
        m_err = 1;
        s_en = 1;
        repeat (ne) @(negedge clk_i);
        m_en = 0;
        s_en = 0;
        @(negedge clk_i);
        chk("main bit errors", 24'(ne), mbe);
        wait_sec(1);
        chk("main errored sec", 1, mes);
        chk("main severe sec", 1, mss);
        chk("main clean sec", 0, mcs);
        chk("side clean sec", 1, scs);
        chk("side errored sec", 0, severe_second_count);
        chk("side severe sec", 0, sss);
        wait_sec(2);
        chk("main clean sec 2", 1, mcs);
        repeat (TK - 100) @(negedge clk_i);
        chk("clean share", 16'h1388, csh);
        chk("severe share", 16'h1388, ssh);
        chk("ratio mantissa", 24'(MANT_MIN), mant);
        chk("ratio exponent", 0, ex);
        $display("test seconds done");
        press();
        chk("view after clear", BES_VIEW_DEFAULT, mvw);
        chk("main bits cleared", 0, mbe);
        chk("side clean cleared", 0, scs);
        chk("elapsed cleared", 0, el);
        side_active_i = 1;
        for (i = 1; i <= 4; i++)
        begin
            press();
            chk("main view", 24'(i % 4), mvw);
            chk("side view", BES_VIEW_DEFAULT, svw);
        end
        chk("side line on", 1, slo);
        $display("test views done");
        s_en = 1;
        s_err = 1;
        repeat (10005) @(negedge clk_i);
        s_en = 0;
        @(negedge clk_i);
        chk("side bit errors sat", 24'(BE_MAX), sbe);
        chk("main untouched", 0, mbe);
        $display("test saturation done");
        press();
        chk("view after sat clear", BES_VIEW_DEFAULT, mvw);
        m_en = 1;
        m_err = 1;
        @(negedge clk_i) m_err = 0;
        wait_sec(1);
        m_en = 0;
        chk("main light errored", 1, mes);
        chk("main light severe", 0, mss);
        $display("test light second done");
        summarize();
    end

    initial
    begin
        #500000;
        n_mismatch++;
        summarize();
    end
endmodule
